// >>> led_sel_consts.vh
// constants for the led indicator source-selection block
// assumes a 25 MHz system clock and 32-bit apb register access
`ifndef LED_SEL_CONSTS_VH
`define LED_SEL_CONSTS_VH

// ****************************************
// clock and timing
// ****************************************
`define CLK_PERIOD_NS 40
`define BLINK_PERIOD_0_MS 50
`define BLINK_PERIOD_1_MS 100
`define BLINK_PERIOD_2_MS 200
`define BLINK_PERIOD_3_MS 500
// half a blink period in clock cycles, rounded down
`define BLINK_HALF_CYC(ms) (((ms) * 1000000) / `CLK_PERIOD_NS / 2)

// ****************************************
// register map: word index, byte address is four times it
// ****************************************
`define ADDR_W 13
`define LED_CFG_IDX 11'h460
`define LED_STAT_IDX 11'h464
`define LED_CFG_ADDR {`LED_CFG_IDX, 2'b00}
`define LED_STAT_ADDR {`LED_STAT_IDX, 2'b00}

// ****************************************
// config field layout and reset
// ****************************************
`define CFG_RST 16'h2610
`define CFG_SRC_A_LSB 0
`define CFG_SRC_B_LSB 4
`define CFG_SRC_C_LSB 8
`define CFG_RATE_LSB 12
`define CFG_RATE_MSB 13

// ****************************************
// status field layout
// ****************************************
`define STAT_LED_LSB 0
`define STAT_LOST_BIT 3
`define STAT_PRBS_BIT 4
`define STAT_PHASE_BIT 5
`define STAT_LINK_BIT 6

// ****************************************
// led source encodings
// ****************************************
`define SRC_LINK 4'h0
`define SRC_LINK_ACT 4'h1
`define SRC_LINK_TX 4'h2
`define SRC_LINK_RX 4'h3
`define SRC_LINK_MASTER 4'h4
`define SRC_LINK_SLAVE 4'h5
`define SRC_ACT 4'h6
`define SRC_LINK_LOST 4'h9
`define SRC_PRBS_ERR 4'ha

`endif

// >>> blink_timer.v
// blink phase generator for the activity indicators
// assumes the half-period counts fit the counter width
`timescale 1ns/100ps
`include "led_sel_consts.vh"

module blink_timer #(
	parameter CNT_W = 24,
	parameter [CNT_W-1:0] HALF_0 = `BLINK_HALF_CYC(`BLINK_PERIOD_0_MS),
	parameter [CNT_W-1:0] HALF_1 = `BLINK_HALF_CYC(`BLINK_PERIOD_1_MS),
	parameter [CNT_W-1:0] HALF_2 = `BLINK_HALF_CYC(`BLINK_PERIOD_2_MS),
	parameter [CNT_W-1:0] HALF_3 = `BLINK_HALF_CYC(`BLINK_PERIOD_3_MS)
) (
	// clock and reset
	input wire clk_sys_in,
	input wire rst_in,
	// control
	input wire [1:0] rate_in,
	// phase
	output wire phase_out
);

	reg [CNT_W-1:0] cnt_q;
	reg phase_q;
	reg [1:0] rate_q;
	reg [CNT_W-1:0] half;

	always @* begin
		case (rate_q)
			2'h0: half = HALF_0;
			2'h1: half = HALF_1;
			2'h2: half = HALF_2;
			default: half = HALF_3;
		endcase
	end

	// a rate change restarts the period with phase low, so a low half-cycle in progress is stretched by a full new half
	always @(posedge clk_sys_in) begin
		if (rst_in) begin
			cnt_q <= {CNT_W{1'b0}};
			phase_q <= 1'b0;
			rate_q <= 2'h2;
		end else begin
			rate_q <= rate_in;
			if (rate_q != rate_in) begin
				cnt_q <= {CNT_W{1'b0}};
				phase_q <= 1'b0;
			end else if (cnt_q >= half - {{(CNT_W-1){1'b0}}, 1'b1}) begin
				cnt_q <= {CNT_W{1'b0}};
				phase_q <= ~phase_q;
			end else begin
				cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
			end
		end
	end

	assign phase_out = phase_q;

endmodule

// >>> led_indicator_select.v
// led indicator source selection, blink and latch logic with an apb slave
// assumes status inputs are synchronous to clk_sys_in and the apb master
// follows the usual setup/access sequence
//
// Functional notes
// - bits 13:12 pick blink period 50, 100, 200 or 500 ms; reset 10.
// - bits 3:0 choose led a source; 0000-0011 link, link+any/tx/rx activity.
// - 0100 link as master, 0101 link as slave, 0110 activity; 0111, 1000 and 1011-1111 reserved.
// - bits 7:4 choose led b source, reset 0001, same encoding.
// - bits 11:8 choose led c source, reset 0110, same encoding.
// - code 1001 latches led on at link loss until status register read.
// - code 1010 latches led on at pattern error until counter cleared.
//
// Design decisions made here: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
`include "led_sel_consts.vh"

module led_indicator_select #(
	parameter CNT_W = 24,
	parameter [CNT_W-1:0] BLINK_HALF_0 = `BLINK_HALF_CYC(`BLINK_PERIOD_0_MS),
	parameter [CNT_W-1:0] BLINK_HALF_1 = `BLINK_HALF_CYC(`BLINK_PERIOD_1_MS),
	parameter [CNT_W-1:0] BLINK_HALF_2 = `BLINK_HALF_CYC(`BLINK_PERIOD_2_MS),
	parameter [CNT_W-1:0] BLINK_HALF_3 = `BLINK_HALF_CYC(`BLINK_PERIOD_3_MS)
) (
	// clock and reset
	input wire clk_sys_in,
	input wire rst_in,

	// apb slave
	input wire psel_in,
	input wire penable_in,
	input wire pwrite_in,
	input wire [`ADDR_W-1:0] paddr_in,
	input wire [31:0] pwdata_in,
	input wire [3:0] pstrb_in,
	output wire [31:0] prdata_out,
	output wire pready_out,
	output wire pslverr_out,

	// phy status
	input wire link_up_in,
	input wire tx_act_in,
	input wire rx_act_in,
	input wire master_in,
	input wire prbs_err_in,
	input wire prbs_cnt_clr_in,
	input wire status_read_in,

	// indicator pins
	output wire indicator_out_a,
	output wire indicator_out_b,
	output wire indicator_out_c
);

	// ****************************************
	// source decode
	// ****************************************

	// one decode shared by all three outputs
	function led_level;
		input [3:0] src;
		input link;
		input tx;
		input rx;
		input master;
		input phase;
		input lost;
		input prbs;
		reg act;
		begin
			act = tx | rx;
			led_level = 1'b0;
			case (src)
				`SRC_LINK: begin
					led_level = link;
				end
				`SRC_LINK_ACT: begin
					led_level = link & (act ? phase : 1'b1);
				end
				`SRC_LINK_TX: begin
					led_level = link & (tx ? phase : 1'b1);
				end
				`SRC_LINK_RX: begin
					led_level = link & (rx ? phase : 1'b1);
				end
				`SRC_LINK_MASTER: begin
					led_level = link & master;
				end
				`SRC_LINK_SLAVE: begin
					led_level = link & ~master;
				end
				`SRC_ACT: begin
					led_level = act & phase;
				end
				`SRC_LINK_LOST: begin
					led_level = lost;
				end
				`SRC_PRBS_ERR: begin
					led_level = prbs;
				end
				default: begin
					// reserved codes keep the led dark
					led_level = 1'b0;
				end
			endcase
		end
	endfunction

	// ****************************************
	// registers
	// ****************************************

	reg [15:0] cfg_q;
	reg [15:0] cfg_d;
	reg link_prev_q;
	reg lost_q;
	reg prbs_q;
	reg [2:0] led_q;
	reg [31:0] prdata_q;
	reg pready_q;
	reg pslverr_q;
	wire phase;
	wire [3:0] src [0:2];
	wire access;
	wire hit_cfg;
	wire hit_stat;
	reg [15:0] stat;

	assign src[0] = cfg_q[`CFG_SRC_A_LSB+3:`CFG_SRC_A_LSB];
	assign src[1] = cfg_q[`CFG_SRC_B_LSB+3:`CFG_SRC_B_LSB];
	assign src[2] = cfg_q[`CFG_SRC_C_LSB+3:`CFG_SRC_C_LSB];

	// ****************************************
	// blink phase
	// ****************************************

	blink_timer #(
		.CNT_W(CNT_W),
		.HALF_0(BLINK_HALF_0),
		.HALF_1(BLINK_HALF_1),
		.HALF_2(BLINK_HALF_2),
		.HALF_3(BLINK_HALF_3)
	) u_blink (
		.clk_sys_in(clk_sys_in),
		.rst_in(rst_in),
		.rate_in(cfg_q[`CFG_RATE_MSB:`CFG_RATE_LSB]),
		.phase_out(phase)
	);

	// ****************************************
	// sticky indications
	// ****************************************

	// a loss or error in the same cycle as its clear wins, so none is missed
	// link_prev starts low so a link held down through reset is not taken as a loss
	always @(posedge clk_sys_in) begin
		if (rst_in) begin
			link_prev_q <= 1'b0;
			lost_q <= 1'b0;
			prbs_q <= 1'b0;
		end else begin
			link_prev_q <= link_up_in;
			if (link_prev_q & ~link_up_in) begin
				lost_q <= 1'b1;
			end else if (status_read_in) begin
				lost_q <= 1'b0;
			end
			if (prbs_err_in) begin
				prbs_q <= 1'b1;
			end else if (prbs_cnt_clr_in) begin
				prbs_q <= 1'b0;
			end
		end
	end

	// ****************************************
	// indicator outputs
	// ****************************************

	genvar i;
	generate
		for (i = 0; i < 3; i = i + 1) begin : g_led
			always @(posedge clk_sys_in) begin
				if (rst_in) begin
					led_q[i] <= 1'b0;
				end else begin
					led_q[i] <= led_level(src[i], link_up_in, tx_act_in, rx_act_in,
						master_in, phase, lost_q, prbs_q);
				end
			end
		end
	endgenerate

	assign indicator_out_a = led_q[0];
	assign indicator_out_b = led_q[1];
	assign indicator_out_c = led_q[2];

	// ****************************************
	// apb slave
	// ****************************************

	// one wait state: pready rises in the second access cycle, so the read
	// mux gets a whole cycle and stays off the bus timing path
	localparam [1:0] ST_IDLE = 2'h0;
	localparam [1:0] ST_ACK = 2'h1;

	reg [1:0] state_q;
	reg [1:0] state_d;

	// one compare serves the error flag, the read mux and the write enable
	function addr_hit;
		input [`ADDR_W-1:0] addr;
		input [`ADDR_W-1:0] target;
		begin
			addr_hit = (addr == target);
		end
	endfunction

	// unmapped reads return zero; the upper half word has no storage
	function [31:0] read_word;
		input sel_cfg;
		input sel_stat;
		input [15:0] cfg;
		input [15:0] status;
		begin
			read_word = 32'h00000000;
			if (sel_cfg) begin
				read_word = {16'h0000, cfg};
			end else if (sel_stat) begin
				read_word = {16'h0000, status};
			end
		end
	endfunction

	assign access = psel_in & penable_in;
	assign hit_cfg = addr_hit(paddr_in, `LED_CFG_ADDR);
	assign hit_stat = addr_hit(paddr_in, `LED_STAT_ADDR);

	// status word: led levels, both latches, blink phase and live link
	always @* begin
		stat = 16'h0000;
		stat[`STAT_LED_LSB+2:`STAT_LED_LSB] = led_q;
		stat[`STAT_LOST_BIT] = lost_q;
		stat[`STAT_PRBS_BIT] = prbs_q;
		stat[`STAT_PHASE_BIT] = phase;
		stat[`STAT_LINK_BIT] = link_up_in;
	end

	// byte lanes above the low half word have no storage
	always @* begin
		cfg_d = cfg_q;
		if (pstrb_in[0]) begin
			cfg_d[7:0] = pwdata_in[7:0];
		end
		if (pstrb_in[1]) begin
			cfg_d[15:8] = pwdata_in[15:8];
		end
	end

	always @* begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				if (access) begin
					state_d = ST_ACK;
				end
			end
			ST_ACK: begin
				state_d = ST_IDLE;
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	// the write lands on the edge that shows pready high to the master
	always @(posedge clk_sys_in) begin
		if (rst_in) begin
			state_q <= ST_IDLE;
			cfg_q <= `CFG_RST;
			prdata_q <= 32'h00000000;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			state_q <= state_d;
			pready_q <= (state_d == ST_ACK);
			pslverr_q <= 1'b0;
			if ((state_q == ST_IDLE) & access) begin
				pslverr_q <= ~(hit_cfg | hit_stat);
				if (pwrite_in) begin
					prdata_q <= 32'h00000000;
				end else begin
					prdata_q <= read_word(hit_cfg, hit_stat, cfg_q, stat);
				end
			end
			if ((state_q == ST_ACK) & access & pwrite_in & hit_cfg) begin
				cfg_q <= cfg_d;
			end
		end
	end

	assign prdata_out = prdata_q;
	assign pready_out = pready_q;
	assign pslverr_out = pslverr_q;

endmodule

// >>> led_lamp.sv
// lamp model for one indicator pin: reports the cycles between its last two changes
// assumes the pin is sampled on the system clock
`timescale 1ns/100ps
module led_lamp (
	input wire logic clk_in,
	input wire logic drive_in,
	output int gap_out
);
	logic last_q = 1'b0;
	int n_q = 0;
	// a lamp only shows level changes, so the gap is all a viewer can judge
	always @(posedge clk_in) begin
		last_q <= drive_in;
		n_q <= (drive_in != last_q) ? 1 : n_q + 1;
		if (drive_in != last_q) gap_out <= n_q;
	end
endmodule

// >>> led_sel_chk.sv
// assertions on the led selector ports, with a shadow of the config register
// assumes only byte lanes 0 and 1 carry config storage
`timescale 1ns/100ps
module led_sel_chk (
	input wire clk_sys_in,
	input wire rst_in,
	input wire psel_in,
	input wire penable_in,
	input wire pwrite_in,
	input wire [12:0] paddr_in,
	input wire [31:0] pwdata_in,
	input wire [3:0] pstrb_in,
	input wire [31:0] prdata_out,
	input wire pready_out,
	input wire pslverr_out,
	input wire link_up_in,
	input wire tx_act_in,
	input wire rx_act_in,
	input wire master_in,
	input wire prbs_err_in,
	input wire status_read_in,
	input wire indicator_out_a,
	input wire indicator_out_b,
	input wire indicator_out_c
);
	logic [15:0] cfg_q;
	wire acc = psel_in & penable_in & pready_out;
	// a write edge changes the source, but the next led value still follows the old one
	wire wr = acc & pwrite_in & (paddr_in == 13'h1180);
	always @(posedge clk_sys_in) begin
		if (rst_in) begin
			cfg_q <= 16'h2610;
		end else if (wr) begin
			if (pstrb_in[0]) cfg_q[7:0] <= pwdata_in[7:0];
			if (pstrb_in[1]) cfg_q[15:8] <= pwdata_in[15:8];
		end
	end
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);
	apb_ack_a: assert property (psel_in & penable_in & !pready_out |=> pready_out)
		else $error("no answer after access");
	unmapped_err_a: assert property (acc & (paddr_in != 13'h1180) & (paddr_in != 13'h1190) |-> pslverr_out & prdata_out == 32'h0)
		else $error("unmapped access not refused");
	cfg_read_a: assert property (acc & !pwrite_in & paddr_in == 13'h1180 |-> prdata_out == {16'h0, cfg_q})
		else $error("config read mismatch");
	link_src_a: assert property (cfg_q[3:0] == 4'h0 & !wr |=> indicator_out_a == $past(link_up_in))
		else $error("led a not following link");
	role_src_a: assert property (cfg_q[7:4] == 4'h4 & !wr |=> indicator_out_b == $past(link_up_in & master_in))
		else $error("led b not showing master link");
	lost_set_a: assert property ($fell(link_up_in) & cfg_q[3:0] == 4'h9 & !wr |-> ##[1:2] indicator_out_a)
		else $error("link loss not shown");
	prbs_set_a: assert property (prbs_err_in & cfg_q[11:8] == 4'ha & !wr |-> ##[1:2] indicator_out_c)
		else $error("pattern error not shown");
	idle_steady_a: assert property (cfg_q[7:4] == 4'h1 & link_up_in & !tx_act_in & !rx_act_in & !wr |=> indicator_out_b)
		else $error("idle link not steady on");
	cover property (wr);
	cover property (pslverr_out);
	cover property (indicator_out_a & cfg_q[3:0] == 4'h9);
endmodule
bind led_indicator_select led_sel_chk u_chk (.*);

// >>> test_led_indicator_select.sv
// self-checking bench: apb master, phy status stimulus, lamp model on output b
// assumes shortened blink half counts of 4, 8, 16 and 32 cycles
`timescale 1ns/100ps
module test_led_indicator_select;
	logic clk_sys_in, rst_in, psel_in, penable_in, pwrite_in, er;
	logic [12:0] paddr_in;
	logic [31:0] pwdata_in, rd;
	logic [3:0] pstrb_in;
	logic link_up_in, tx_act_in, rx_act_in, master_in, prbs_err_in, prbs_cnt_clr_in, status_read_in;
	wire [31:0] prdata_out;
	wire pready_out, pslverr_out, indicator_out_a, indicator_out_b, indicator_out_c;
	wire [2:0] leds = {indicator_out_c, indicator_out_b, indicator_out_a};
	int n_fail, checks_done, gap;
	int h[4] = '{4, 8, 16, 32};
	led_indicator_select #(.CNT_W(8), .BLINK_HALF_0(8'h04), .BLINK_HALF_1(8'h08), .BLINK_HALF_2(8'h10),
		.BLINK_HALF_3(8'h20)) dut (.*);
	led_lamp lamp (.clk_in(clk_sys_in), .drive_in(indicator_out_b), .gap_out(gap));
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys_in);
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	// the request stays put until pready is seen, however long that takes
	task automatic apb(input logic w, input logic [12:0] a, input logic [31:0] d);
		@(posedge clk_sys_in);
		psel_in <= 1;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= d;
		tick(1);
		penable_in <= 1;
		do begin
			tick(1);
		end while (pready_out !== 1'b1);
		rd = prdata_out;
		er = pslverr_out;
		psel_in <= 0;
		penable_in <= 0;
	endtask
	task automatic finish_test;
		$display("checks %0d failures %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic t_regs;
		apb(0, 13'h1180, 0);
		chk("cfg reset", 32'h2610, rd);
		apb(0, 13'h1190, 0);
		chk("stat reset", 32'h43, rd & 32'hffffffdf);
		chk("mapped err", 0, er);
		apb(1, 13'h11a0, 32'hffff);
		chk("unmapped", 1, er);
		apb(0, 13'h1180, 0);
		chk("cfg kept", 32'h2610, rd);
		pstrb_in <= 4'h1;
		apb(1, 13'h1180, 32'h3a5b);
		pstrb_in <= 4'hf;
		apb(0, 13'h1180, 0);
		chk("cfg lanes", 32'h265b, rd);
		apb(1, 13'h1180, 32'h2610);
		$display("test regs done");
	endtask
	task automatic t_codes;
		logic e;
		logic [31:0] d;
		for (int m = 0; m < 2; m++) for (int c = 0; c < 16; c++) begin
			master_in <= m[0];
			d = {20'h2, c[3:0], c[3:0], c[3:0]};
			apb(1, 13'h1180, d);
			apb(0, 13'h1180, 0);
			chk("cfg rw", d, rd);
			tick(2);
			e = c < 4 || (c == 4 && m == 1) || (c == 5 && m == 0);
			chk("leds", {3{e}}, leds);
		end
		$display("test codes done");
	endtask
	task automatic t_latch(input logic [31:0] d, input logic lost);
		apb(1, 13'h1180, d);
		if (lost) link_up_in <= 0;
		else prbs_err_in <= 1;
		tick(1);
		link_up_in <= 1;
		prbs_err_in <= 0;
		tick(3);
		chk("latched", 7, leds);
		if (lost) status_read_in <= 1;
		else prbs_cnt_clr_in <= 1;
		tick(1);
		status_read_in <= 0;
		prbs_cnt_clr_in <= 0;
		tick(3);
		chk("cleared", 0, leds);
		$display("test latch done");
	endtask
	task automatic t_blink;
		rx_act_in <= 1;
		for (int r = 0; r < 4; r++) begin
			apb(1, 13'h1180, {18'h0, r[1:0], 12'h111});
			tick(3 * h[r] + 4);
			chk("blink gap", h[r], gap);
		end
		rx_act_in <= 0;
		tick(3);
		chk("steady", 7, leds);
		$display("test blink done");
	endtask
	initial begin
		clk_sys_in = 0;
		forever #20 clk_sys_in = ~clk_sys_in;
	end
	initial begin
		{psel_in, penable_in, pwrite_in, tx_act_in, rx_act_in, master_in} = 0;
		{prbs_err_in, prbs_cnt_clr_in, status_read_in, paddr_in, pwdata_in} = 0;
		pstrb_in = 4'hf;
		rst_in = 1;
		link_up_in = 1;
		tick(4);
		rst_in <= 0;
		t_regs;
		t_codes;
		t_latch(32'h2999, 1);
		t_latch(32'h2aaa, 0);
		t_blink;
		finish_test;
	end
	initial begin
		#800000;
		n_fail++;
		finish_test;
	end
endmodule
